/* File: src/eeprom_dev.sv */
// Overview of operation
// R1: write aborted if select drops before last bit
// R2: last data rise locks the write
// R3: later clock rise aborts unstarted write
// R4: erase aborted if select drops early
// R5: erase locked at address end rise
// R6: host drops select while clock low
// R7: host raises select with clock low
// R8: output floats except read and status
// R9: status shown after select low 200ns
// R10: busy ignores commands, ready accepts them
// R11: new start bit floats the status output
// R12: host holds data low while polling
// R13: dummy zero driven on last address rise
// R14: host stops clocking once ready shows
// R15: zeros skipped, first one is start
// R16: programming starts on following select fall
// R17: programming needs write enable, reads don't
// R18: address width parameter sets all counts
// R19: rise count cleared on select low
`include "eeprom_cfg.svh"
`default_nettype none
module eeprom_dev
    import eeprom_pkg::*;
#(
    parameter int ADDR_W      = `ADDR_W_DEF,
    parameter int PROG_CYCLES = `PROG_CYC_DEF
) (
    input  wire logic    sys_clk,
    input  wire logic    rst_n,
    serial_eeprom_if.dev link,
    output logic         busy,
    output logic         write_enabled
);
    localparam int DW = `DATA_BITS;
    // start bit, opcode and address; data follows
    localparam logic [5:0] CMD_BITS = 6'(3 + ADDR_W);         // [R18]
    localparam logic [5:0] WR_BITS  = 6'(3 + ADDR_W + DW);    // [R18]
    localparam logic [2:0] LOW_MIN  = 3'(`SEL_LOW_CYC);

    function automatic logic is_prog(input logic [1:0] op,
                                     input logic [1:0] sub,
                                     input logic       with_data);
        if (with_data)
            return op == `OP_WRITE || (op == `OP_EXT && sub == `SUB_WRITE_ALL_COMMAND);
        return op == `OP_ERASE || (op == `OP_EXT && sub == `SUB_ERASE_ALL_COMMAND);
    endfunction

    logic [15:0] mem [2**ADDR_W];

    // pins cross in through two flops before anything reads them
    logic [2:0] sync1_r;
    logic [2:0] sync2_r;
    logic [2:0] prev_r;
    logic       cs_s;
    logic       sk_s;
    logic       di_s;
    logic       cs_rise;
    logic       cs_fall;
    logic       sk_rise;
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sync
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    sync1_r[g] <= 1'b0;
                    sync2_r[g] <= 1'b0;
                    prev_r[g]  <= 1'b0;
                end else begin
                    sync2_r[g] <= sync1_r[g];
                    prev_r[g]  <= sync2_r[g];
                    unique case (g)
                        0: sync1_r[g] <= link.chip_sel;
                        1: sync1_r[g] <= link.serial_clock_in;
                        default: sync1_r[g] <= link.serial_data_in;
                    endcase
                end
            end
        end
    endgenerate
    assign cs_s    = sync2_r[0];
    assign sk_s    = sync2_r[1];
    assign di_s    = sync2_r[2];
    assign cs_rise = cs_s && !prev_r[0];
    assign cs_fall = !cs_s && prev_r[0];
    assign sk_rise = sk_s && !prev_r[1];

    dev_state_t        state_r,   state_nxt;
    logic [5:0]        cnt_r,     cnt_nxt;
    logic [31:0]       in_r,      in_nxt;
    logic [15:0]       rd_sh_r,   rd_sh_nxt;
    logic [4:0]        rd_left_r, rd_left_nxt;
    logic [ADDR_W-1:0] rd_addr_r, rd_addr_nxt;
    logic [16:0]       prog_r,    prog_nxt;
    logic              wen_r,     wen_nxt;
    logic              arm_r,     arm_nxt;
    logic              show_r,    show_nxt;
    logic [2:0]        low_r,     low_nxt;
    logic              dq_r,      dq_nxt;
    logic              oe_r,      oe_nxt;
    logic              busy_r,    busy_nxt;
    logic              mem_we;
    logic              mem_all;
    logic [ADDR_W-1:0] mem_addr;
    logic [15:0]       mem_wdata;
    logic              is_busy;
    logic [ADDR_W-1:0] a_next;

    assign is_busy = prog_r != 17'h00000;
    assign a_next  = rd_addr_r + ADDR_W'(1);

    always_comb begin
        state_nxt   = state_r;
        cnt_nxt     = cnt_r;
        in_nxt      = in_r;
        rd_sh_nxt   = rd_sh_r;
        rd_left_nxt = rd_left_r;
        rd_addr_nxt = rd_addr_r;
        prog_nxt    = is_busy ? prog_r - 17'h00001 : prog_r;   // [R10]
        wen_nxt     = wen_r;
        arm_nxt     = arm_r;
        show_nxt    = show_r;
        low_nxt     = (!cs_s && low_r != LOW_MIN) ? low_r + 3'h1 : low_r;
        mem_we      = 1'b0;
        mem_all     = 1'b0;
        mem_addr    = in_r[DW +: ADDR_W];
        mem_wdata   = in_r[DW-1:0];
        if (!cs_s) begin
            state_nxt = DS_IDLE;
            cnt_nxt   = 6'h00;                                  // [R19]
            show_nxt  = 1'b0;
        end
        if (cs_fall && state_r == DS_CMD) begin
            // only the exact final count starts work; shorter is an
            // abort, and every rise past it aborts as well
            if (wen_r && cnt_r == WR_BITS &&                    // [R17]
                is_prog(in_r[DW+ADDR_W +: 2], in_r[DW+ADDR_W-2 +: 2],
                        1'b1)) begin            // [R1] [R2] [R3] [R16]
                mem_we   = 1'b1;
                mem_all  = in_r[DW+ADDR_W +: 2] == `OP_EXT;
                prog_nxt = 17'(PROG_CYCLES);
                arm_nxt  = 1'b1;
            end else if (wen_r && cnt_r == CMD_BITS &&          // [R17]
                is_prog(in_r[ADDR_W +: 2], in_r[ADDR_W-2 +: 2],
                        1'b0)) begin            // [R4] [R5] [R16]
                mem_we    = 1'b1;
                mem_all   = in_r[ADDR_W +: 2] == `OP_EXT;
                mem_addr  = in_r[ADDR_W-1:0];
                mem_wdata = 16'hffff;
                prog_nxt  = 17'(PROG_CYCLES);
                arm_nxt   = 1'b1;
            end
        end
        if (cs_rise) begin
            state_nxt = DS_HUNT;
            low_nxt   = 3'h0;
            if (arm_r && low_r == LOW_MIN)
                show_nxt = 1'b1;                                // [R9]
        end else if (sk_rise && cs_s) begin
            unique case (state_r)
                DS_HUNT: if (di_s) begin                        // [R15]
                    show_nxt  = 1'b0;                           // [R11]
                    arm_nxt   = 1'b0;
                    cnt_nxt   = 6'h01;
                    in_nxt    = 32'h00000000;
                    state_nxt = is_busy ? DS_HOLD : DS_CMD;     // [R10]
                end
                DS_CMD: begin
                    in_nxt  = {in_r[30:0], di_s};
                    cnt_nxt = (cnt_r == 6'h3f) ? cnt_r : cnt_r + 6'h01;
                    if (cnt_nxt == CMD_BITS) begin
                        if (in_nxt[ADDR_W +: 2] == `OP_READ) begin
                            rd_addr_nxt = in_nxt[ADDR_W-1:0];
                            rd_sh_nxt   = mem[in_nxt[ADDR_W-1:0]];
                            rd_left_nxt = 5'(DW);
                            state_nxt   = DS_READ;              // [R13]
                        end else if (in_nxt[ADDR_W +: 2] == `OP_EXT) begin
                            if (in_nxt[ADDR_W-2 +: 2] == `SUB_WEN)
                                wen_nxt = 1'b1;
                            else if (in_nxt[ADDR_W-2 +: 2] == `SUB_WDS)
                                wen_nxt = 1'b0;
                        end
                    end
                end
                DS_READ: begin
                    // auto increment wraps at the top of the array
                    if (rd_left_r == 5'h01) begin
                        rd_addr_nxt = a_next;
                        rd_sh_nxt   = mem[a_next];
                        rd_left_nxt = 5'(DW);
                    end else begin
                        rd_sh_nxt   = {rd_sh_r[14:0], 1'b0};
                        rd_left_nxt = rd_left_r - 5'h01;
                    end
                end
                default: ;
            endcase
        end
        // drive only in read or while status is shown
        oe_nxt = cs_s && (state_nxt == DS_READ || show_nxt);    // [R8]
        dq_nxt = 1'b0;
        if (show_nxt)
            dq_nxt = !(prog_nxt != 17'h00000);                  // [R9]
        else if (state_r == DS_READ && sk_rise && cs_s)
            dq_nxt = rd_sh_r[15];
        else if (state_r == DS_READ)
            dq_nxt = dq_r;
        busy_nxt = prog_nxt != 17'h00000;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r   <= DS_IDLE;
            cnt_r     <= 6'h00;
            in_r      <= 32'h00000000;
            rd_sh_r   <= 16'h0000;
            rd_left_r <= 5'h00;
            rd_addr_r <= '0;
            prog_r    <= 17'h00000;
            wen_r     <= 1'b0;
            arm_r     <= 1'b0;
            show_r    <= 1'b0;
            low_r     <= 3'h0;
            dq_r      <= 1'b0;
            oe_r      <= 1'b0;
            busy_r    <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            cnt_r     <= cnt_nxt;
            in_r      <= in_nxt;
            rd_sh_r   <= rd_sh_nxt;
            rd_left_r <= rd_left_nxt;
            rd_addr_r <= rd_addr_nxt;
            prog_r    <= prog_nxt;
            wen_r     <= wen_nxt;
            arm_r     <= arm_nxt;
            show_r    <= show_nxt;
            low_r     <= low_nxt;
            dq_r      <= dq_nxt;
            oe_r      <= oe_nxt;
            busy_r    <= busy_nxt;
        end
    end

    // the addressed word, or every word for the all commands, is written at the start of the program time
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < 2**ADDR_W; i++)
            if (mem_we && (mem_all || mem_addr == ADDR_W'(i)))
                mem[i] <= mem_wdata;
    end

    assign link.data_out    = dq_r;
    assign link.data_out_oe = oe_r;
    assign busy             = busy_r;
    assign write_enabled    = wen_r;
endmodule
`default_nettype wire

/* File: src/eeprom_cfg.svh */
`ifndef EEPROM_CFG_SVH
`define EEPROM_CFG_SVH
// address width of the part: 6, 8 or 10
`define ADDR_W_DEF    6
`define DATA_BITS     16
`define CLK_NS        50
`define SEL_LOW_NS    200
// least time rounds up
`define SEL_LOW_CYC   ((`SEL_LOW_NS + `CLK_NS - 1) / `CLK_NS)
`define PROG_TIME_NS  5000000
// longest time rounds down
`define PROG_CYC_DEF  (`PROG_TIME_NS / `CLK_NS)
// host serial clock half period in system clocks
`define SK_HALF_CYC   8
`define POLL_LIMIT    200000
`define OP_EXT        2'b00
`define OP_WRITE      2'b01
`define OP_READ       2'b10
`define OP_ERASE      2'b11
`define SUB_WDS       2'b00
`define SUB_WRITE_ALL_COMMAND      2'b01
`define SUB_ERASE_ALL_COMMAND      2'b10
`define SUB_WEN       2'b11
`endif

/* File: src/eeprom_pkg.sv */
`default_nettype none
package eeprom_pkg;
    typedef enum logic [2:0] {
        CMD_READ  = 3'h0,
        CMD_WRITE = 3'h1,
        CMD_ERASE = 3'h2,
        CMD_WEN   = 3'h3,
        CMD_WDS   = 3'h4,
        CMD_WRITE_ALL_COMMAND  = 3'h5,
        CMD_ERASE_ALL_COMMAND  = 3'h6
    } cmd_t;
    typedef enum logic [2:0] {
        DS_IDLE = 3'h0,
        DS_HUNT = 3'h1,
        DS_CMD  = 3'h2,
        DS_READ = 3'h3,
        DS_HOLD = 3'h4
    } dev_state_t;
    typedef enum logic [2:0] {
        HS_IDLE  = 3'h0,
        HS_SETUP = 3'h1,
        HS_SHIFT = 3'h2,
        HS_GAP   = 3'h3,
        HS_POLL  = 3'h4
    } host_state_t;
endpackage
`default_nettype wire

/* File: src/serial_eeprom_if.sv */
`default_nettype none
interface serial_eeprom_if;
    logic chip_sel;
    logic serial_clock_in;
    logic serial_data_in;
    logic data_out;
    logic data_out_oe;
    logic data_out_line;
    // the line is pulled low while the device floats it
    assign data_out_line = data_out_oe ? data_out : 1'b0;
    modport dev  (input chip_sel, serial_clock_in, serial_data_in,
                  output data_out, data_out_oe);
    modport host (output chip_sel, serial_clock_in, serial_data_in,
                  input data_out_line);
endinterface
`default_nettype wire

/* File: src/eeprom_host.sv */
`include "eeprom_cfg.svh"
`default_nettype none
module eeprom_host
    import eeprom_pkg::*;
#(
    parameter int ADDR_W = `ADDR_W_DEF
) (
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    serial_eeprom_if.host          link,
    input  wire logic              cmd_valid,
    input  wire cmd_t              cmd_op,
    input  wire logic [ADDR_W-1:0] cmd_addr,
    input  wire logic [15:0]       cmd_wdata,
    output logic                   cmd_ready,
    output logic [15:0]            rd_data,
    output logic                   done,
    output logic                   timeout
);
    localparam logic [3:0]  HALF     = 4'(`SK_HALF_CYC - 1);
    localparam logic [5:0]  CMD_BITS = 6'(3 + ADDR_W);
    localparam logic [5:0]  DATA_B   = 6'(`DATA_BITS);
    localparam logic [19:0] GAP_CYC  = 20'(`SEL_LOW_CYC + 1);

    logic dq_s1_r;
    logic dq_s2_r;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dq_s1_r <= 1'b0;
            dq_s2_r <= 1'b0;
        end else begin
            dq_s1_r <= link.data_out_line;
            dq_s2_r <= dq_s1_r;
        end
    end

    host_state_t state_r, state_nxt;
    logic [3:0]  ph_r,    ph_nxt;
    logic [5:0]  rise_r,  rise_nxt;
    logic [5:0]  tot_r,   tot_nxt;
    logic [31:0] tx_r,    tx_nxt;
    logic [15:0] rx_r,    rx_nxt;
    logic [19:0] wait_r,  wait_nxt;
    logic        rd_r,    rd_nxt;
    logic        prog_r,  prog_nxt;
    logic        cs_r,    cs_nxt;
    logic        sk_r,    sk_nxt;
    logic        di_r,    di_nxt;
    logic        rdy_r,   rdy_nxt;
    logic        done_r,  done_nxt;
    logic        to_r,    to_nxt;
    logic [1:0]  op;
    logic [ADDR_W-1:0] afield;
    logic        has_data;

    always_comb begin
        op       = `OP_EXT;
        afield   = cmd_addr;
        has_data = 1'b0;
        unique case (cmd_op)
            CMD_READ:  op = `OP_READ;
            CMD_WRITE: begin
                op       = `OP_WRITE;
                has_data = 1'b1;
            end
            CMD_ERASE: op = `OP_ERASE;
            CMD_WEN:   afield = {`SUB_WEN, (ADDR_W-2)'(0)};
            CMD_WDS:   afield = {`SUB_WDS, (ADDR_W-2)'(0)};
            CMD_WRITE_ALL_COMMAND: begin
                afield   = {`SUB_WRITE_ALL_COMMAND, (ADDR_W-2)'(0)};
                has_data = 1'b1;
            end
            default:   afield = {`SUB_ERASE_ALL_COMMAND, (ADDR_W-2)'(0)};
        endcase
    end

    always_comb begin
        state_nxt = state_r;
        ph_nxt    = ph_r;
        rise_nxt  = rise_r;
        tot_nxt   = tot_r;
        tx_nxt    = tx_r;
        rx_nxt    = rx_r;
        wait_nxt  = wait_r;
        rd_nxt    = rd_r;
        prog_nxt  = prog_r;
        cs_nxt    = cs_r;
        sk_nxt    = sk_r;
        di_nxt    = di_r;
        rdy_nxt   = rdy_r;
        done_nxt  = 1'b0;
        to_nxt    = 1'b0;
        unique case (state_r)
            HS_IDLE: if (cmd_valid) begin
                tot_nxt  = CMD_BITS + (has_data || cmd_op == CMD_READ
                                       ? DATA_B : 6'h00);
                tx_nxt   = 32'({1'b1, op, afield, cmd_wdata})
                           << (6'd13 - 6'(ADDR_W));
                rd_nxt   = cmd_op == CMD_READ;
                prog_nxt = has_data || cmd_op == CMD_ERASE
                           || cmd_op == CMD_ERASE_ALL_COMMAND;
                rdy_nxt  = 1'b0;
                rise_nxt = 6'h00;
                ph_nxt   = 4'h0;
                state_nxt = HS_SETUP;
            end
            HS_SETUP: begin
                // select rises while the clock is held low
                cs_nxt    = 1'b1;                               // [R7]
                sk_nxt    = 1'b0;
                di_nxt    = tx_r[31];
                state_nxt = HS_SHIFT;
            end
            HS_SHIFT: begin
                ph_nxt = ph_r + 4'h1;
                if (ph_r == HALF) begin
                    ph_nxt = 4'h0;
                    if (sk_r) begin
                        if (rd_r && rise_r > CMD_BITS)
                            rx_nxt = {rx_r[14:0], dq_s2_r};
                        sk_nxt = 1'b0;
                        tx_nxt = {tx_r[30:0], 1'b0};
                        di_nxt = tx_r[30];
                    end else if (rise_r == tot_r) begin
                        cs_nxt    = 1'b0;                       // [R6]
                        di_nxt    = 1'b0;
                        wait_nxt  = 20'h00000;
                        state_nxt = prog_r ? HS_GAP : HS_IDLE;
                        done_nxt  = !prog_r;
                        rdy_nxt   = !prog_r;
                    end else begin
                        sk_nxt   = 1'b1;
                        rise_nxt = rise_r + 6'h01;
                    end
                end
            end
            HS_GAP: begin
                wait_nxt = wait_r + 20'h00001;
                if (wait_r == GAP_CYC) begin
                    cs_nxt    = 1'b1;
                    wait_nxt  = 20'h00000;
                    state_nxt = HS_POLL;
                end
            end
            default: begin
                // clock stays low and data in stays low while polling
                di_nxt   = 1'b0;                                // [R12]
                wait_nxt = wait_r + 20'h00001;
                if (dq_s2_r || wait_r == 20'(`POLL_LIMIT)) begin
                    cs_nxt    = 1'b0;                           // [R14]
                    done_nxt  = dq_s2_r;
                    to_nxt    = !dq_s2_r;
                    rdy_nxt   = 1'b1;
                    state_nxt = HS_IDLE;
                end
            end
        endcase
        if (state_r == HS_IDLE && !cmd_valid)
            rdy_nxt = 1'b1;
        else if (state_r == HS_IDLE)
            rdy_nxt = 1'b0;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= HS_IDLE;
            ph_r    <= 4'h0;
            rise_r  <= 6'h00;
            tot_r   <= 6'h00;
            tx_r    <= 32'h00000000;
            rx_r    <= 16'h0000;
            wait_r  <= 20'h00000;
            rd_r    <= 1'b0;
            prog_r  <= 1'b0;
            cs_r    <= 1'b0;
            sk_r    <= 1'b0;
            di_r    <= 1'b0;
            rdy_r   <= 1'b0;
            done_r  <= 1'b0;
            to_r    <= 1'b0;
        end else begin
            state_r <= state_nxt;
            ph_r    <= ph_nxt;
            rise_r  <= rise_nxt;
            tot_r   <= tot_nxt;
            tx_r    <= tx_nxt;
            rx_r    <= rx_nxt;
            wait_r  <= wait_nxt;
            rd_r    <= rd_nxt;
            prog_r  <= prog_nxt;
            cs_r    <= cs_nxt;
            sk_r    <= sk_nxt;
            di_r    <= di_nxt;
            rdy_r   <= rdy_nxt;
            done_r  <= done_nxt;
            to_r    <= to_nxt;
        end
    end

    assign link.chip_sel        = cs_r;
    assign link.serial_clock_in = sk_r;
    assign link.serial_data_in  = di_r;
    assign cmd_ready            = rdy_r;
    assign rd_data              = rx_r;
    assign done                 = done_r;
    assign timeout              = to_r;
endmodule
`default_nettype wire

/* File: sim/serial_eeprom_properties.sv */
`default_nettype none
module serial_eeprom_properties #(
    parameter int ADDR_W      = 6,
    parameter int PROG_CYCLES = 200
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic chip_sel,
    input wire logic serial_clock_in,
    input wire logic serial_data_in,
    input wire logic data_out,
    input wire logic data_out_oe,
    input wire logic busy,
    input wire logic write_enabled
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int ER_N = 3 + ADDR_W;
    localparam int WR_N = ER_N + 16;
    logic       on_r;
    logic       stat_r;
    logic [5:0] cnt_r;
    logic [5:0] last_r;
    int         bcnt_r;
    // pins come straight from host flops, so edges are seen one clock apart
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            on_r   <= 1'b0;
            stat_r <= 1'b0;
            cnt_r  <= 6'h00;
            last_r <= 6'h00;
            bcnt_r <= 0;
        end else begin
            if (!chip_sel) begin
                on_r  <= 1'b0;
                cnt_r <= 6'h00;
            end else if ($rose(serial_clock_in)
                         && (on_r || serial_data_in)) begin
                on_r  <= 1'b1;
                cnt_r <= (cnt_r == 6'h3f) ? cnt_r : cnt_r + 6'h01;
            end
            if ($fell(chip_sel))
                last_r <= cnt_r;
            if ($rose(busy))
                stat_r <= 1'b1;
            else if (chip_sel && !on_r && $rose(serial_clock_in)
                     && serial_data_in)
                stat_r <= 1'b0;
            bcnt_r <= busy ? bcnt_r + 1 : 0;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_start_bit;
        chip_sel && $rose(serial_clock_in) && serial_data_in;
    endsequence
    sequence s_floated;
        ##[1:5] !data_out_oe;
    endsequence
    sequence s_ready;
        ##[1:5] data_out;
    endsequence
    property p_float_off;
        $fell(chip_sel) |-> s_floated;
    endproperty
    a_float_off: assert property (p_float_off)
        else $error("output still driven after deselect");
    property p_busy_low;
        busy && data_out_oe |-> !data_out;
    endproperty
    a_busy_low: assert property (p_busy_low)
        else $error("status not low while busy");
    property p_ready_high;
        $fell(busy) && data_out_oe |-> s_ready;
    endproperty
    a_ready_high: assert property (p_ready_high)
        else $error("status not high once ready");
    property p_timer_bound;
        bcnt_r <= PROG_CYCLES;
    endproperty
    a_timer_bound: assert property (p_timer_bound)
        else $error("program period too long");
    property p_start_floats;
        stat_r && data_out_oe ##0 s_start_bit |-> s_floated;
    endproperty
    a_start_floats: assert property (p_start_floats)
        else $error("status kept after start bit");
    property p_dummy_zero;
        $rose(data_out_oe) && !stat_r |-> !data_out;
    endproperty
    a_dummy_zero: assert property (p_dummy_zero)
        else $error("read did not begin with zero");
    property p_exact_count;
        $rose(busy) |-> (last_r == ER_N) || (last_r == WR_N);
    endproperty
    a_exact_count: assert property (p_exact_count)
        else $error("program began at wrong rise count");
    property p_needs_enable;
        $rose(busy) |-> write_enabled && !chip_sel;
    endproperty
    a_needs_enable: assert property (p_needs_enable)
        else $error("program began without enable or select fall");
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
`default_nettype none
module testbench
    import eeprom_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PROG = 200;
    logic        sys_clk;
    logic        rst_n;
    logic        cmd_valid;
    cmd_t        cmd_op;
    logic [5:0]  cmd_addr;
    logic [15:0] cmd_wdata;
    logic [15:0] rd_data;
    logic        done;
    logic        timeout;
    logic        busy;
    logic        write_enabled;
    logic        busy_b;
    int          n_errors;
    int          checks;
    int          n_prog;
    serial_eeprom_if link ();
    serial_eeprom_if link_b ();
    eeprom_host #(.ADDR_W(6)) i_eeprom_host (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .link      (link),
        .cmd_valid (cmd_valid),
        .cmd_op    (cmd_op),
        .cmd_addr  (cmd_addr),
        .cmd_wdata (cmd_wdata),
        .cmd_ready (),
        .rd_data   (rd_data),
        .done      (done),
        .timeout   (timeout)
    );
    eeprom_dev #(.ADDR_W(6), .PROG_CYCLES(PROG)) i_eeprom_dev (
        .sys_clk       (sys_clk),
        .rst_n         (rst_n),
        .link          (link),
        .busy          (busy),
        .write_enabled (write_enabled)
    );
    // second device is bit-banged so frames can be cut at any rise
    eeprom_dev #(.ADDR_W(6), .PROG_CYCLES(PROG)) i_eeprom_dev_b (
        .sys_clk       (sys_clk),
        .rst_n         (rst_n),
        .link          (link_b),
        .busy          (busy_b),
        .write_enabled ()
    );
    serial_eeprom_properties #(.ADDR_W(6), .PROG_CYCLES(PROG)) i_props (
        .sys_clk         (sys_clk),
        .rst_n           (rst_n),
        .chip_sel        (link.chip_sel),
        .serial_clock_in (link.serial_clock_in),
        .serial_data_in  (link.serial_data_in),
        .data_out        (link.data_out),
        .data_out_oe     (link.data_out_oe),
        .busy            (busy),
        .write_enabled   (write_enabled)
    );
    always #25 sys_clk = ~sys_clk;
    always @(posedge busy) n_prog = n_prog + 1;
    task automatic summarize;
        $display("errors=%0d checks=%0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic run(input cmd_t op, input logic [5:0] a,
                       input logic [15:0] d);
        int k;
        cmd_op    = op;
        cmd_addr  = a;
        cmd_wdata = d;
        cmd_valid = 1'b1;
        tick(1);
        cmd_valid = 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 5000) begin
            tick(1);
            k++;
        end
        chk({14'h0000, done, timeout}, 16'h0002);
        tick(2);
    endtask
    task automatic rd(input logic [5:0] a, input logic [15:0] exp);
        run(CMD_READ, a, 16'h0000);
        chk(rd_data, exp);
    endtask
    task automatic bang(input logic [31:0] v, input int n);
        link_b.chip_sel = 1'b1;
        for (int i = n - 1; i >= 0; i--) begin
            link_b.serial_data_in = v[i];
            tick(8);
            link_b.serial_clock_in = 1'b1;
            tick(8);
            link_b.serial_clock_in = 1'b0;
        end
        tick(8);
        link_b.serial_data_in = 1'b0;
        link_b.chip_sel = 1'b0;
        tick(6);
    endtask
    task automatic prog(input logic [31:0] v, input int n, input logic ok);
        bang(v, n);
        chk({15'h0000, busy_b}, {15'h0000, ok});
        chk({15'h0000, link_b.data_out_oe}, 16'h0000);
        if (ok) begin
            link_b.chip_sel = 1'b1;
            tick(6);
            chk({14'h0, link_b.data_out_oe, link_b.data_out}, 16'h2);
            tick(PROG);
            chk({14'h0, link_b.data_out_oe, link_b.data_out}, 16'h3);
            link_b.serial_data_in = 1'b1;
            tick(8);
            link_b.serial_clock_in = 1'b1;
            tick(8);
            chk({15'h0000, link_b.data_out_oe}, 16'h0000);
            link_b.serial_clock_in = 1'b0;
            link_b.serial_data_in = 1'b0;
            link_b.chip_sel = 1'b0;
            tick(6);
        end
    endtask
    initial begin
        repeat (60000) @(posedge sys_clk);
        n_errors++;
        summarize();
    end
    initial begin
        sys_clk = 1'b0;
        rst_n = 1'b0;
        cmd_valid = 1'b0;
        cmd_op = CMD_READ;
        cmd_addr = 6'h00;
        cmd_wdata = 16'h0000;
        n_errors = 0;
        checks = 0;
        n_prog = 0;
        link_b.chip_sel = 1'b0;
        link_b.serial_clock_in = 1'b0;
        link_b.serial_data_in = 1'b0;
        tick(16);
        rst_n = 1'b1;
        tick(2);
        prog(32'h1451111, 25, 1'b0);
        run(CMD_WEN, 6'h00, 16'h0000);
        chk({15'h0000, write_enabled}, 16'h0001);
        run(CMD_WRITE, 6'h05, 16'ha5c3);
        rd(6'h05, 16'ha5c3);
        run(CMD_WDS, 6'h00, 16'h0000);
        chk({15'h0000, write_enabled}, 16'h0000);
        rd(6'h05, 16'ha5c3);
        run(CMD_WEN, 6'h00, 16'h0000);
        run(CMD_ERASE, 6'h05, 16'h0000);
        rd(6'h05, 16'hffff);
        run(CMD_WRITE_ALL_COMMAND, 6'h00, 16'h1357);
        rd(6'h00, 16'h1357);
        rd(6'h3f, 16'h1357);
        run(CMD_ERASE_ALL_COMMAND, 6'h00, 16'h0000);
        rd(6'h3f, 16'hffff);
        chk(n_prog[15:0], 16'h0004);
        // enable, then erase and write cut one rise short and one long
        prog(32'h0000130, 9, 1'b0);
        prog(32'h00000e1, 8, 1'b0);
        prog(32'h0000386, 10, 1'b0);
        prog(32'h00001c3, 12, 1'b1);
        prog(32'h0a1df77, 24, 1'b0);
        prog(32'h287ddde, 26, 1'b0);
        prog(32'h143beef, 25, 1'b1);
        summarize();
    end
endmodule
`default_nettype wire
